// [shared/p4cs_pkg.sv]
package p4cs_pkg;

    // Register map
    localparam logic [7:0] ADDR_PIN_LATCH  = 8'hD8;
    localparam logic [7:0] ADDR_BASE_FIRST = 8'hE8;
    localparam logic [7:0] ADDR_CTRL_A     = 8'hF8;
    localparam logic [7:0] ADDR_CTRL_B     = 8'hF9;
    localparam logic [7:0] ADDR_EXT_CTRL   = 8'hFA;

    // Reset values
    localparam logic [3:0] LATCH_RESET = 4'hF;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [3:0] PIN_IDLE    = 4'hF;

    // Field layout: one nibble per pin in the control pair, invert bits in ext control
    localparam int PIN_COUNT = 4;
    localparam int FIELD_W   = 4;
    localparam int MODE_LSB  = 0;
    localparam int IGN_LSB   = 2;
    localparam int INV_LSB   = 4;
    localparam int IRQ3_PIN  = 2;
    localparam int IRQ2_PIN  = 3;

    typedef enum logic [1:0] {
        MODE_GPIO,
        MODE_RD,
        MODE_WR,
        MODE_RDWR
    } p4cs_mode_t;

    // External data memory cycle as the core drives it
    typedef struct packed {
        logic [15:0] addr;
        logic        rd_n;
        logic        wr_n;
    } p4cs_xacc_t;

    typedef struct packed {
        p4cs_mode_t  mode;
        logic [1:0]  ign;
        logic        inv;
        logic [15:0] base;
    } p4cs_pin_cfg_t;

endpackage : p4cs_pkg

// [hw/p4cs_sync.sv]
`timescale 1ns/1ps
module p4cs_sync import p4cs_pkg::*; #(
    parameter int         WIDTH   = PIN_COUNT,
    parameter logic [3:0] RST_VAL = PIN_IDLE
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stage_one <= RST_VAL[WIDTH-1:0];
            sync_out  <= RST_VAL[WIDTH-1:0];
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule : p4cs_sync

// [hw/p4cs_addr_match.sv]
`timescale 1ns/1ps
module p4cs_addr_match import p4cs_pkg::*; (
    // Compare settings
    input  wire logic [15:0] base,
    input  wire logic [1:0]  ign_bits,
    // Access address
    input  wire logic [15:0] addr,
    output logic             hit
);

    // Low bits below the ignore count never take part in the compare
    wire [15:0] care_mask = 16'hFFFF << ign_bits;

    assign hit = ((addr ^ base) & care_mask) == 16'h0000;

endmodule : p4cs_addr_match

// [hw/p4cs_top.sv]
`timescale 1ns/1ps
module p4cs_top import p4cs_pkg::*; (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // External data memory cycle from the core
    input  wire p4cs_xacc_t xacc,
    // Port pins
    input  wire logic [3:0] pin_in,
    output logic      [3:0] pin_out,
    output logic      [3:0] pin_oe,
    // Interrupt levels to the core
    output logic            ext_irq_two_n,
    output logic            ext_irq_three_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [3:0]    port4_pin_latch;
    logic [3:0]    latch_prev;
    logic [7:0]    strobe_mode_ctrl_a;
    logic [7:0]    strobe_mode_ctrl_b;
    logic [7:0]    port_ext_ctrl;
    logic [7:0]    strobe_base_addr_high [PIN_COUNT];
    logic [7:0]    strobe_base_addr_low  [PIN_COUNT];
    logic [3:0]    pin_sync;
    p4cs_pin_cfg_t cfg                   [PIN_COUNT];
    logic [3:0]    hit;
    logic [3:0]    strobe_act;
    logic [3:0]    is_gpio;
    logic [3:0]    kick;
    logic [3:0]    next_out;
    logic [3:0]    next_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode

    wire       wr_latch  = sfr_wr && (sfr_addr == ADDR_PIN_LATCH);
    wire       wr_ctrl_a = sfr_wr && (sfr_addr == ADDR_CTRL_A);
    wire       wr_ctrl_b = sfr_wr && (sfr_addr == ADDR_CTRL_B);
    wire       wr_ext    = sfr_wr && (sfr_addr == ADDR_EXT_CTRL);
    wire       in_base   = (sfr_addr[7:3] == ADDR_BASE_FIRST[7:3]);
    wire [1:0] base_idx  = sfr_addr[2:1];
    wire       base_low  = sfr_addr[0];
    wire       wr_base   = sfr_wr && in_base;

    wire [7:0] base_rd   = base_low ? strobe_base_addr_low[base_idx]
                                    : strobe_base_addr_high[base_idx];

    // Pins read back their sampled level; upper nibble reads zero
    wire [7:0] next_rdata =
        (sfr_addr == ADDR_PIN_LATCH) ? {4'h0, pin_sync} :
        (sfr_addr == ADDR_CTRL_A)    ? strobe_mode_ctrl_a :
        (sfr_addr == ADDR_CTRL_B)    ? strobe_mode_ctrl_b :
        (sfr_addr == ADDR_EXT_CTRL)  ? port_ext_ctrl :
        in_base                      ? base_rd : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port4_pin_latch    <= LATCH_RESET;
            strobe_mode_ctrl_a <= CTRL_RESET;
            strobe_mode_ctrl_b <= CTRL_RESET;
            port_ext_ctrl      <= CTRL_RESET;
        end else begin
            if (wr_latch)  port4_pin_latch    <= sfr_wdata[3:0];
            if (wr_ctrl_a) strobe_mode_ctrl_a <= sfr_wdata;
            if (wr_ctrl_b) strobe_mode_ctrl_b <= sfr_wdata;
            if (wr_ext)    port_ext_ctrl      <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                strobe_base_addr_high[i] <= CTRL_RESET;
                strobe_base_addr_low[i]  <= CTRL_RESET;
            end
        end else if (wr_base) begin
            if (base_low) strobe_base_addr_low[base_idx]  <= sfr_wdata;
            else          strobe_base_addr_high[base_idx] <= sfr_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin input sampling

    p4cs_sync #(
        .WIDTH   (PIN_COUNT),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin strobe generation

    wire [15:0] ctrl_ab = {strobe_mode_ctrl_b, strobe_mode_ctrl_a};
    wire        acc_rd  = ~xacc.rd_n;
    wire        acc_wr  = ~xacc.wr_n;

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        assign cfg[g].mode = p4cs_mode_t'(ctrl_ab[FIELD_W*g+MODE_LSB +: 2]);
        assign cfg[g].ign  = ctrl_ab[FIELD_W*g+IGN_LSB +: 2];
        assign cfg[g].inv  = port_ext_ctrl[INV_LSB+g];
        assign cfg[g].base = {strobe_base_addr_high[g], strobe_base_addr_low[g]};

        p4cs_addr_match u_match (
            .base     (cfg[g].base),
            .ign_bits (cfg[g].ign),
            .addr     (xacc.addr),
            .hit      (hit[g])
        );

        assign strobe_act[g] = hit[g] && (
            ((cfg[g].mode == MODE_RD)   && acc_rd) ||
            ((cfg[g].mode == MODE_WR)   && acc_wr) ||
            ((cfg[g].mode == MODE_RDWR) && (acc_rd || acc_wr)));
        assign is_gpio[g]  = (cfg[g].mode == MODE_GPIO);
        // Strobe level follows the polarity choice; latch only reaches GPIO pins
        assign next_out[g] = is_gpio[g] ? port4_pin_latch[g]
                           : (cfg[g].inv ? strobe_act[g] : ~strobe_act[g]);
        // GPIO pins quasi-bidirectional: strong low, strong high for one cycle on a rise, else pull-up; strobe pins always driven
        assign next_oe[g]  = is_gpio[g] ? (~port4_pin_latch[g] | kick[g]) : 1'b1;
    end

    assign kick = port4_pin_latch & ~latch_prev;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latch_prev      <= LATCH_RESET;
            pin_out         <= PIN_IDLE;
            pin_oe          <= 4'h0;
            ext_irq_two_n   <= 1'b1;
            ext_irq_three_n <= 1'b1;
        end else begin
            latch_prev      <= port4_pin_latch;
            pin_out         <= next_out;
            pin_oe          <= next_oe;
            ext_irq_two_n   <= is_gpio[IRQ2_PIN] ? pin_sync[IRQ2_PIN] : 1'b1;
            ext_irq_three_n <= is_gpio[IRQ3_PIN] ? pin_sync[IRQ3_PIN] : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_latch_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_latch |=> (port4_pin_latch == $past(sfr_wdata[3:0]));
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port latch did not take written nibble");

    property p_upper_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        (sfr_rd && sfr_addr == ADDR_PIN_LATCH) |=> (sfr_rdata[7:4] == 4'h0);
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("port read upper nibble not zero");

    property p_gpio_low;
        @(posedge ref_clk) disable iff (sys_rst)
        (is_gpio[0] && !port4_pin_latch[0]) |=> (pin_oe[0] && !pin_out[0]);
    endproperty
    a_gpio_low: assert property (p_gpio_low)
        else $error("gpio pin not driven low for zero latch");

    property p_irq_three;
        @(posedge ref_clk) disable iff (sys_rst)
        is_gpio[IRQ3_PIN] |=> (ext_irq_three_n == $past(pin_sync[IRQ3_PIN]));
    endproperty
    a_irq_three: assert property (p_irq_three)
        else $error("interrupt three does not follow pin 2");

    property p_rd_strobe;
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg[0].mode == MODE_RD && hit[0] && acc_rd && !cfg[0].inv) |=> !pin_out[0];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe)
        else $error("read strobe missing on pin 0");

    property p_wr_strobe;
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg[0].mode == MODE_WR && hit[0] && acc_wr && cfg[0].inv) |=> pin_out[0];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe)
        else $error("inverted write strobe missing on pin 0");

    property p_idle_level;
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg[0].mode == MODE_RDWR && !hit[0]) |=> (pin_out[0] != $past(cfg[0].inv));
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("strobe active outside address range");

    property p_strobe_drives;
        @(posedge ref_clk) disable iff (sys_rst)
        (!is_gpio[1] && $stable(port_ext_ctrl) && !acc_rd && !acc_wr)
            |=> (pin_oe[1] && (pin_out[1] != $past(port_ext_ctrl[INV_LSB+1])));
    endproperty
    a_strobe_drives: assert property (p_strobe_drives)
        else $error("strobe pin follows latch");

    property p_kick;
        @(posedge ref_clk) disable iff (sys_rst)
        (is_gpio[3] && kick[3]) |=> (pin_oe[3] && pin_out[3]);
    endproperty
    a_kick: assert property (p_kick)
        else $error("gpio rise not driven high for one cycle");

    property p_gpio_release;
        @(posedge ref_clk) disable iff (sys_rst)
        (is_gpio[1] && port4_pin_latch[1] && !kick[1]) |=> !pin_oe[1];
    endproperty
    a_gpio_release: assert property (p_gpio_release)
        else $error("gpio pin with latch one still driven");

    property p_irq_two;
        @(posedge ref_clk) disable iff (sys_rst)
        is_gpio[IRQ2_PIN] |=> (ext_irq_two_n == $past(pin_sync[IRQ2_PIN]));
    endproperty
    a_irq_two: assert property (p_irq_two)
        else $error("interrupt two does not follow pin 3");

    property p_irq_idle;
        @(posedge ref_clk) disable iff (sys_rst)
        !is_gpio[IRQ2_PIN] |=> ext_irq_two_n;
    endproperty
    a_irq_idle: assert property (p_irq_idle)
        else $error("interrupt two active while pin is a strobe");

    property p_rdwr_strobe;
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg[2].mode == MODE_RDWR && hit[2] && (acc_rd || acc_wr))
            |=> (pin_out[2] == $past(cfg[2].inv));
    endproperty
    a_rdwr_strobe: assert property (p_rdwr_strobe)
        else $error("read or write strobe missing on pin 2");

    property p_wr_ignores_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (cfg[1].mode == MODE_WR && acc_rd && !acc_wr) |=> (pin_out[1] != $past(cfg[1].inv));
    endproperty
    a_wr_ignores_read: assert property (p_wr_ignores_read)
        else $error("write strobe pin pulsed on a read");

    property p_base_write;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_base && base_low && base_idx == 2'h0) |=> (strobe_base_addr_low[0] == $past(sfr_wdata));
    endproperty
    a_base_write: assert property (p_base_write)
        else $error("pin 0 low base byte write lost");

    property p_ext_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_ext |=> (port_ext_ctrl == $past(sfr_wdata));
    endproperty
    a_ext_write: assert property (p_ext_write)
        else $error("polarity register write lost");

    property p_read_data;
        @(posedge ref_clk) disable iff (sys_rst)
        (sfr_rd && sfr_addr == ADDR_CTRL_A) |=> (sfr_rdata == $past(strobe_mode_ctrl_a));
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("control register a read back wrong");

    property p_mask_match;
        @(posedge ref_clk) disable iff (sys_rst)
        hit[0] |-> ((xacc.addr >> cfg[0].ign) == (cfg[0].base >> cfg[0].ign));
    endproperty
    a_mask_match: assert property (p_mask_match)
        else $error("address hit outside masked range");

    property p_ctrl_write;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_ctrl_b |=> (strobe_mode_ctrl_b == $past(sfr_wdata));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control register b write lost");

    c_rd_strobe: cover property (@(posedge ref_clk) disable iff (sys_rst)
        cfg[0].mode == MODE_RD && hit[0] && acc_rd);
    c_wr_strobe: cover property (@(posedge ref_clk) disable iff (sys_rst)
        cfg[1].mode == MODE_WR && hit[1] && acc_wr);
    c_masked_hit: cover property (@(posedge ref_clk) disable iff (sys_rst)
        hit[0] && cfg[0].ign == 2'h2 && xacc.addr[1:0] == 2'h3);
    c_gpio_kick: cover property (@(posedge ref_clk) disable iff (sys_rst)
        is_gpio[3] && kick[3]);

endmodule : p4cs_top

// [testbench/p4cs_periph.sv]
`timescale 1ns/1ps
module p4cs_periph (
    // Drive from the port
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // Resolved pin levels
    output logic      [3:0] pin_in
);
    // Peripherals only listen; a released pin floats up to the pull-up level
    assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule : p4cs_periph

// [testbench/test_port4_chip_select_strobes.sv]
`timescale 1ns/1ps
module test_port4_chip_select_strobes import p4cs_pkg::*;;
    logic        ref_clk, sys_rst, sfr_wr, sfr_rd;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
    p4cs_xacc_t  xacc;
    logic [3:0]  pin_in, pin_out, pin_oe, inv, expv, v;
    logic        ext_irq_two_n, ext_irq_three_n;
    logic [31:0] lf;
    logic [15:0] bs [4];
    logic [1:0]  md [4];
    logic [1:0]  ig [4];
    int          n_mismatch, n_compared;

    p4cs_top u_p4cs_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .xacc(xacc), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_irq_two_n(ext_irq_two_n), .ext_irq_three_n(ext_irq_three_n));
    p4cs_periph u_p4cs_periph (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : nxt

    // Strobe level one cycle after the access
    function automatic logic exp_pin(input int p, input p4cs_xacc_t x);
        logic act;
        act = (((x.addr ^ bs[p]) >> ig[p]) == 16'h0)
            && ((md[p][0] && !x.rd_n) || (md[p][1] && !x.wr_n));
        return inv[p] ? act : !act;
    endfunction : exp_pin

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        chk(sfr_rdata, exp);
    endtask : rd_chk

    task automatic wrap_up();
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        #(25 * 30000);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
        xacc = '{addr: 16'h0, rd_n: 1'b1, wr_n: 1'b1};
        lf = 32'h3E4E;
        n_mismatch = 0;
        n_compared = 0;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        rd_chk(ADDR_PIN_LATCH, 8'h0F);
        rd_chk(ADDR_CTRL_A, CTRL_RESET);
        wr(8'h10, 8'h5A);
        rd_chk(8'h10, 8'h00);
        // General I/O: driven zeros, released ones, interrupt levels follow pins
        for (int k = 0; k < 2; k++) begin
            v = k ? 4'hA : 4'h5;
            wr(ADDR_PIN_LATCH, {4'h0, v});
            @(negedge ref_clk);
            chk({4'h0, pin_oe}, {4'h0, ~v | (v & ~(k ? 4'h5 : 4'hF))});
            repeat (5) @(negedge ref_clk);
            chk({4'h0, pin_oe}, {4'h0, ~v});
            chk({4'h0, pin_out & pin_oe}, 8'h00);
            chk({7'h0, ext_irq_three_n}, {7'h0, v[IRQ3_PIN]});
            chk({7'h0, ext_irq_two_n}, {7'h0, v[IRQ2_PIN]});
            rd_chk(ADDR_PIN_LATCH, {4'h0, v});
        end
        // Random strobe configurations, ignore counts 0 and 3 forced at the ends
        for (int r = 0; r < 6; r++) begin
            for (int p = 0; p < 4; p++) begin
                lf = nxt(lf);
                bs[p]  = lf[15:0];
                md[p]  = 2'(1 + lf[17:16] % 3);
                ig[p]  = (r == 0) ? 2'h0 : (r == 5) ? 2'h3 : lf[19:18];
                inv[p] = lf[20];
                wr(ADDR_BASE_FIRST + 8'(2 * p), bs[p][15:8]);
                wr(ADDR_BASE_FIRST + 8'(2 * p + 1), bs[p][7:0]);
            end
            wr(ADDR_CTRL_A, {ig[1], md[1], ig[0], md[0]});
            wr(ADDR_CTRL_B, {ig[3], md[3], ig[2], md[2]});
            wr(ADDR_EXT_CTRL, {inv, 4'h0});
            wr(ADDR_PIN_LATCH, lf[7:0]);
            rd_chk(ADDR_CTRL_B, {ig[3], md[3], ig[2], md[2]});
            rd_chk(ADDR_EXT_CTRL, {inv, 4'h0});
            for (int n = 0; n <= 40; n++) begin
                @(negedge ref_clk);
                if (n > 0) begin
                    chk({4'h0, pin_out}, {4'h0, expv});
                    chk({4'h0, pin_oe}, 8'h0F);
                end
                lf = nxt(lf);
                xacc.addr = lf[3] ? lf[31:16] : bs[lf[5:4]] ^ {13'h0, lf[2:0]};
                xacc.rd_n = (n == 40) || (lf[9:8] != 2'h1);
                xacc.wr_n = (n == 40) || (lf[9:8] != 2'h2);
                for (int p = 0; p < 4; p++)
                    expv[p] = exp_pin(p, xacc);
            end
            chk({6'h0, ext_irq_two_n, ext_irq_three_n}, 8'h03);
        end
        wrap_up();
    end
endmodule : test_port4_chip_select_strobes
